// ==== arsio_pkg.sv ====
// Constants and types shared by the recloser signal block
package arsio_pkg;
  localparam int NUM_REQ = 5;
  localparam int NUM_IN = 9;
  localparam int IRQ_W = 11;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DEAD_W = 16;
  localparam int MS_DIV_W = 16;
  // Input bit positions
  localparam int IN_ENABLE = 0;
  localparam int IN_RELEASE = 1;
  localparam int IN_LOCK = 2;
  localparam int IN_CRIT = 3;
  localparam int IN_REQ0 = 4;
  // Extra interrupt bits beyond input events
  localparam int IRQ_LOCK = 9;
  localparam int IRQ_SHOT = 10;
  // Control fields
  localparam int CTRL_ON = 0;
  localparam int CTRL_EXT_SEL = 1;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EV_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DEAD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h18;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [NUM_IN-1:0] EV_EN_RST = 9'h1ff;
  localparam logic [DEAD_W-1:0] DEAD_RST = 16'h0001;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 11'h000;
  // Millisecond tick timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1_000_000 * MS_TIME_US;

  typedef enum logic [3:0] {
    ST_READY = 4'b0001,
    ST_DEAD = 4'b0010,
    ST_LOCKED = 4'b0100,
    ST_OFF = 4'b1000
  } arsio_state_t;

  typedef struct packed {
    logic [NUM_REQ-1:0] reclose_request;
    logic critical_lock_request;
    logic force_lock_input;
    logic lock_release_input;
    logic recloser_enable_input;
  } arsio_in_t;

  typedef struct packed {
    logic lockout_ind;
    logic [NUM_REQ-1:0] shot_from_ind;
    logic dead_time_active_ind;
    logic recloser_disabled_ind;
    logic recloser_enabled_ind;
  } arsio_ind_t;

  typedef struct packed {
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
  } arsio_event_t;
endpackage

// ==== arsio_edge.sv ====
// Input change detector with per-input event enables
`timescale 1ns/1ps
module arsio_edge #(
  parameter int W = 9
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] sig,
  input wire logic [W-1:0] ev_en,
  output logic [W-1:0] raw_rise,
  output logic [W-1:0] ev_rise,
  output logic [W-1:0] ev_fall
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sig;
    end
  end

  assign raw_rise = sig & ~prev_reg;

  // One-cycle strobes, gated by configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      ev_rise <= '0;
      ev_fall <= '0;
    end else begin
      ev_rise <= sig & ~prev_reg & ev_en; // [R08] [R09] [R17]
      ev_fall <= ~sig & prev_reg & ev_en; // [R08] [R09] [R17]
    end
  end
endmodule

// ==== arsio_core.sv ====
// Recloser input and indication handling with register port
// Contract
// R01 - Enable recloser while the selected enable input is active, else disable.
// R02 - The enable input matters only when the select setting is on.
// R03 - Manual reset input releases the locked state.
// R04 - Locking input locks; only a manual reset returns to ready.
// R05 - Critical request locks immediately, with no shot run.
// R06 - Five requests ranked strictly; a higher one overrides lower ones.
// R07 - A newly active request with conditions met applies a shot.
// R08 - Every input change makes an event and updates registers and indications.
// R09 - Each input's event generation is switchable by configuration.
// R10 - Outputs are indications only; breaker commands come from elsewhere.
// R11 - Enabled indication high whenever the function is enabled.
// R12 - Disabled indication high when select is on and enable input inactive.
// R13 - In-progress indication high while dead time is counted.
// R14 - Request indications one to four mark the shot's originating request.
// R15 - Fifth request indication marks a shot from the lowest request.
// R16 - Locked indication high while in locked mode.
// R17 - Indications are levels; events are one-cycle strobes on input edges.
`timescale 1ns/1ps
module arsio_core
  import arsio_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input arsio_pkg::arsio_in_t inputs,
  output arsio_pkg::arsio_ind_t ind,
  output arsio_pkg::arsio_event_t events,
  output logic irq,
  input wire logic [arsio_pkg::ADDR_W-1:0] addr,
  input wire logic [arsio_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [arsio_pkg::DATA_W-1:0] rdata
);
  import arsio_pkg::*;

  function automatic logic [2:0] top_req(input logic [NUM_REQ-1:0] r);
    logic [2:0] idx;
    idx = 3'(NUM_REQ);
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (r[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [1:0] ctrl_reg;
  logic [NUM_IN-1:0] ev_en_reg;
  logic [DEAD_W-1:0] dead_reg;
  logic [IRQ_W-1:0] irq_st_reg;
  logic [IRQ_W-1:0] irq_st_next;
  logic [IRQ_W-1:0] irq_en_reg;
  arsio_state_t state_reg;
  arsio_state_t state_next;
  logic [2:0] shot_reg;
  logic [DEAD_W-1:0] cnt_reg;
  logic [MS_DIV_W-1:0] div_reg;
  logic ms_tick;
  logic enabled;
  logic lock_now;
  logic dead_done;
  logic [NUM_IN-1:0] in_vec;
  logic [NUM_IN-1:0] raw_rise;
  logic [NUM_REQ-1:0] req_rise;
  logic [2:0] new_req;
  logic take_req;
  logic [NUM_IN-1:0] ev_rise;
  logic [NUM_IN-1:0] ev_fall;

  assign in_vec = inputs;
  // Whole struct from one driver, not per field
  assign events = {ev_rise, ev_fall};
  assign req_rise = raw_rise[IN_REQ0 +: NUM_REQ];
  assign new_req = top_req(req_rise);

  arsio_edge #(
    .W(NUM_IN)
  ) u_edge (
    .clock(clock),
    .rst(rst),
    .sig(in_vec),
    .ev_en(ev_en_reg),
    .raw_rise(raw_rise),
    .ev_rise(ev_rise),
    .ev_fall(ev_fall)
  );

  // Enable input counts only when selected
  assign enabled = ctrl_reg[CTRL_ON] &
    (~ctrl_reg[CTRL_EXT_SEL] | inputs.recloser_enable_input); // [R01] [R02]
  assign lock_now = inputs.force_lock_input | raw_rise[IN_CRIT]; // [R04] [R05]

  // Millisecond tick paces the dead-time count
  always_ff @(posedge clock) begin
    if (rst) begin
      div_reg <= '0;
    end else if (div_reg == MS_DIV_W'(MS_CYCLES - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign ms_tick = (div_reg == MS_DIV_W'(MS_CYCLES - 1));
  assign dead_done = ms_tick && (cnt_reg == '0);

  // Only a strictly higher request may preempt a running shot
  assign take_req = (new_req != 3'(NUM_REQ)) &&
    ((state_reg == ST_READY) || (state_reg == ST_DEAD && new_req < shot_reg)); // [R06] [R07]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_READY: begin
        if (lock_now) begin
          state_next = ST_LOCKED; // [R04] [R05]
        end else if (!enabled) begin
          state_next = ST_OFF; // [R01]
        end else if (take_req) begin
          state_next = ST_DEAD; // [R07]
        end
      end
      ST_DEAD: begin
        if (lock_now) begin
          state_next = ST_LOCKED; // [R05]
        end else if (!enabled) begin
          state_next = ST_OFF; // [R01]
        end else if (!take_req && dead_done) begin
          state_next = ST_READY;
        end
      end
      ST_LOCKED: begin
        // Release loses to a still-active locking input
        if (inputs.lock_release_input && !lock_now) begin
          state_next = enabled ? ST_READY : ST_OFF; // [R03] [R04]
        end
      end
      ST_OFF: begin
        if (lock_now) begin
          state_next = ST_LOCKED; // [R04]
        end else if (enabled) begin
          state_next = ST_READY; // [R01]
        end
      end
      default: begin
        state_next = ST_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Shot origin and dead-time counter
  always_ff @(posedge clock) begin
    if (rst) begin
      shot_reg <= 3'(NUM_REQ);
      cnt_reg <= '0;
    end else if (state_next == ST_DEAD && take_req) begin
      shot_reg <= new_req; // [R06]
      cnt_reg <= dead_reg;
    end else if (state_next != ST_DEAD) begin
      shot_reg <= 3'(NUM_REQ);
      cnt_reg <= '0;
    end else if (ms_tick) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Indications are levels only; no breaker command leaves here [R10]
  always_comb begin
    ind = '0;
    ind.recloser_enabled_ind = (state_reg != ST_OFF); // [R11]
    ind.recloser_disabled_ind = ctrl_reg[CTRL_EXT_SEL] & ~inputs.recloser_enable_input; // [R12]
    ind.dead_time_active_ind = (state_reg == ST_DEAD); // [R13] [R17]
    ind.lockout_ind = (state_reg == ST_LOCKED); // [R16] [R17]
    for (int i = 0; i < NUM_REQ; i++) begin
      ind.shot_from_ind[i] = (state_reg == ST_DEAD) && (shot_reg == 3'(i)); // [R14] [R15]
    end
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      ev_en_reg <= EV_EN_RST;
      dead_reg <= DEAD_RST;
      irq_en_reg <= IRQ_EN_RST;
    end else if (wr) begin
      case (addr)
        OFS_CTRL: ctrl_reg <= wdata[1:0]; // [R02]
        OFS_EV_EN: ev_en_reg <= wdata[NUM_IN-1:0]; // [R09]
        OFS_DEAD: dead_reg <= wdata[DEAD_W-1:0];
        OFS_IRQ_EN: irq_en_reg <= wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky event bits; a new event wins over a clear
  always_comb begin
    irq_st_next = irq_st_reg;
    if (wr && addr == OFS_IRQ_CLR) begin
      irq_st_next = irq_st_reg & ~wdata[IRQ_W-1:0];
    end
    irq_st_next[NUM_IN-1:0] = irq_st_next[NUM_IN-1:0] | events.rise | events.fall; // [R08]
    irq_st_next[IRQ_LOCK] = irq_st_next[IRQ_LOCK] |
      (state_next == ST_LOCKED && state_reg != ST_LOCKED);
    irq_st_next[IRQ_SHOT] = irq_st_next[IRQ_SHOT] |
      (state_reg == ST_DEAD && state_next == ST_READY);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_st_reg <= '0;
    end else begin
      irq_st_reg <= irq_st_next;
    end
  end

  assign irq = |(irq_st_reg & irq_en_reg);

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        OFS_CTRL: rdata <= DATA_W'(ctrl_reg);
        OFS_EV_EN: rdata <= DATA_W'(ev_en_reg);
        OFS_DEAD: rdata <= DATA_W'(dead_reg);
        OFS_STATUS: rdata <= DATA_W'({shot_reg, state_reg, in_vec}); // [R08]
        OFS_IRQ_ST: rdata <= DATA_W'(irq_st_reg);
        OFS_IRQ_EN: rdata <= DATA_W'(irq_en_reg);
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_crit_edge;
    inputs.critical_lock_request && !$past(inputs.critical_lock_request);
  endsequence

  sequence s_locked_hold;
    ind.lockout_ind && !ind.dead_time_active_ind;
  endsequence

  a_crit_locks: assert property (s_crit_edge |=> s_locked_hold) // [R05]
    else $error("critical request did not lock");
  a_lock_holds: assert property (inputs.force_lock_input |=> ind.lockout_ind) // [R04]
    else $error("locking input did not lock");
  a_release_unlocks: assert property (ind.lockout_ind && inputs.lock_release_input && !lock_now
    |=> !ind.lockout_ind) // [R03]
    else $error("manual reset did not release lock");
  a_ext_select: assert property (ctrl_reg[CTRL_ON] && !ctrl_reg[CTRL_EXT_SEL] && !lock_now
    && !ind.lockout_ind |=> ind.recloser_enabled_ind) // [R02]
    else $error("enable input consulted while unselected");
  a_off_when_low: assert property (ctrl_reg[CTRL_EXT_SEL] && !inputs.recloser_enable_input
    && !ind.lockout_ind && !lock_now |=> !ind.recloser_enabled_ind) // [R01]
    else $error("enabled while enable input inactive");
  a_disabled_ind: assert property (ind.recloser_disabled_ind ==
    (ctrl_reg[CTRL_EXT_SEL] && !inputs.recloser_enable_input)) // [R12]
    else $error("disabled indication wrong");
  a_req_starts: assert property (ind.recloser_enabled_ind && !ind.lockout_ind && !lock_now
    && !ind.dead_time_active_ind && enabled && inputs.reclose_request[0]
    && !$past(inputs.reclose_request[0]) |=> ind.shot_from_ind[0]) // [R07] [R14]
    else $error("request did not start a shot");
  a_prio_override: assert property (ind.shot_from_ind[4] && enabled && !lock_now
    && req_rise[0] |=> ind.shot_from_ind[0] && !ind.shot_from_ind[4]) // [R06] [R15]
    else $error("higher request did not override");
  a_dead_ind: assert property (ind.dead_time_active_ind == (|ind.shot_from_ind)) // [R13]
    else $error("dead time indication without shot origin");
  a_event_pulse: assert property (inputs.force_lock_input && !$past(inputs.force_lock_input)
    && ev_en_reg[IN_LOCK] |=> events.rise[IN_LOCK] ##1 !events.rise[IN_LOCK]) // [R08] [R17]
    else $error("input edge event not a single strobe");
  a_event_mask: assert property (!ev_en_reg[IN_CRIT] |=> !events.rise[IN_CRIT] && !events.fall[IN_CRIT]) // [R09]
    else $error("masked input produced an event");
  a_fall_strobe: assert property (!inputs.force_lock_input && $past(inputs.force_lock_input) && !$past(rst)
    && ev_en_reg[IN_LOCK] |=> events.fall[IN_LOCK] ##1 !events.fall[IN_LOCK]) // [R08] [R17]
    else $error("input fall event not a single strobe");
  a_off_no_shot: assert property (!ind.recloser_enabled_ind |=> !ind.dead_time_active_ind) // [R01]
    else $error("shot started while function off");
  a_lock_stays: assert property (ind.lockout_ind && !inputs.lock_release_input
    |=> ind.lockout_ind && !ind.dead_time_active_ind) // [R04] [R05]
    else $error("lock left without manual reset");
  a_shot_onehot: assert property ($onehot0(ind.shot_from_ind)) // [R14] [R15]
    else $error("more than one request indication");
endmodule

// ==== arsio_stage_model.sv ====
// Model of the protection stages that drive the recloser inputs
`timescale 1ns/1ps
module arsio_stage_model
  import arsio_pkg::*;
#(
  parameter int HOLD = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] sel,
  input wire logic [arsio_pkg::NUM_IN-1:0] base,
  output arsio_pkg::arsio_in_t sig
);
  logic [7:0] hold_reg;
  logic [3:0] sel_reg;
  logic [NUM_IN-1:0] lvl;
  // A stage start stays up while the fault lasts, so the pulse is held
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_reg <= 8'h00;
      sel_reg <= 4'h0;
    end else if (go) begin
      hold_reg <= 8'(HOLD);
      sel_reg <= sel;
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end
  always_comb begin
    lvl = base;
    if (hold_reg != 8'h00) begin
      lvl[sel_reg] = 1'b1;
    end
  end
  assign sig = lvl;
endmodule

// ==== test_arsio_core.sv ====
// Self-checking bench for the recloser signal block
`timescale 1ns/1ps
module test_arsio_core;
  import arsio_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic irq;
  arsio_in_t inputs;
  arsio_ind_t ind;
  arsio_event_t events;
  logic [NUM_IN-1:0] base = 9'h000;
  logic go = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [NUM_IN-1:0] rise_seen = 9'h000;
  logic [NUM_IN-1:0] fall_seen = 9'h000;
  logic seen_clr = 1'b0;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  initial begin
    forever #12.5 clock = ~clock;
  end
  // Short millisecond tick keeps dead times to tens of cycles
  arsio_core #(.MS_CYCLES(4)) dut_u (.clock(clock), .rst(rst), .inputs(inputs), .ind(ind), .events(events),
    .irq(irq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  arsio_stage_model stage_u (.clock(clock), .rst(rst), .go(go), .sel(sel), .base(base), .sig(inputs));
  always @(posedge clock) begin
    rise_seen <= (seen_clr ? 9'h000 : rise_seen) | events.rise;
    fall_seen <= (seen_clr ? 9'h000 : fall_seen) | events.fall;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Event collectors have one owner; the clear goes through a strobe
  task automatic clr_seen();
    seen_clr <= 1'b1;
    @(posedge clock);
    seen_clr <= 1'b0;
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask
  task automatic fire(input int i);
    @(posedge clock);
    go <= 1'b1;
    sel <= 4'(i);
    @(posedge clock);
    go <= 1'b0;
    hold(2);
  endtask
  task automatic lv(input logic [NUM_IN-1:0] v);
    @(posedge clock);
    base <= v;
    hold(2);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd_chk("ctrl", OFS_CTRL, 32'h1);
    rd_chk("ev_en", OFS_EV_EN, 32'h1ff);
    rd_chk("irq_en", OFS_IRQ_EN, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    check("ind_idle", 32'(ind), 32'h001);
    wr_reg(OFS_DEAD, 32'd10);
    for (int i = 0; i < NUM_REQ; i++) begin
      clr_seen();
      fire(IN_REQ0 + i);
      check("shot_ind", 32'(ind), {23'h0, 1'b0, 5'(1 << i), 3'b101});
      check("rise_ev", 32'(rise_seen), 32'(1 << (IN_REQ0 + i)));
      hold(60);
      check("dead_end", 32'(ind), 32'h001);
      check("fall_ev", 32'(fall_seen), 32'(1 << (IN_REQ0 + i)));
    end
    rd_chk("irq_shot", OFS_IRQ_ST, 32'h000005f0);
    check("irq_masked", 32'(irq), 32'h0);
    rd_chk("dead", OFS_DEAD, 32'h0000000a);
    // Lower request first, then a higher and again a lower one
    fire(8);
    fire(IN_REQ0);
    check("override", 32'(ind), 32'h00d);
    fire(7);
    check("no_override", 32'(ind), 32'h00d);
    hold(60);
    lv(9'h0c0);
    check("same_edge", 32'(ind), 32'h025);
    lv(9'h000);
    hold(60);
    wr_reg(OFS_EV_EN, 32'h0);
    clr_seen();
    lv(9'h001);
    hold(1);
    check("ev_masked", 32'(rise_seen), 32'h0);
    check("sel_off", 32'(ind), 32'h001);
    wr_reg(OFS_EV_EN, 32'h1ff);
    wr_reg(OFS_CTRL, 32'h3);
    hold(2);
    check("ext_on", 32'(ind), 32'h001);
    lv(9'h000);
    check("ext_off", 32'(ind), 32'h002);
    fire(IN_REQ0);
    check("off_req", 32'(ind), 32'h002);
    wr_reg(OFS_CTRL, 32'h1);
    hold(25);
    check("sel_clear", 32'(ind), 32'h001);
    fire(IN_REQ0);
    lv(9'h008);
    check("critical", 32'(ind), 32'h101);
    fire(5);
    check("locked_req", 32'(ind), 32'h101);
    lv(9'h00a);
    check("release", 32'(ind), 32'h001);
    lv(9'h000);
    hold(25);
    wr_reg(OFS_IRQ_CLR, 32'h7ff);
    rd_chk("irq_clr", OFS_IRQ_ST, 32'h0);
    wr_reg(OFS_IRQ_EN, 32'h200);
    lv(9'h004);
    check("irq_lock", 32'(irq), 32'h1);
    check("force", 32'(ind), 32'h101);
    rd_chk("status", OFS_STATUS, 32'h0000a804);
    lv(9'h006);
    check("rel_blocked", 32'(ind), 32'h101);
    lv(9'h002);
    check("rel_ok", 32'(ind), 32'h001);
    rd_chk("irq_st", OFS_IRQ_ST, 32'h206);
    wr_reg(OFS_IRQ_CLR, 32'h200);
    hold(1);
    check("irq_drop", 32'(irq), 32'h0);
    report_and_stop();
  end
endmodule
